// ---- design/pmctl_pkg.sv ----
// Purpose: Shared constants and types of the module management control.
// Assumes: System clock of 50 MHz; link side clocked by the serial clock.
// Notes: Only the init timeout is a top-level parameter, defaulting to INIT_CYC.
package pmctl_pkg;
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned CLK_PERIOD_NS = 20;
    // Initialisation window after power-up or reset release
    localparam int unsigned T_INIT_MS = 2000;
    localparam int unsigned INIT_CYC = T_INIT_MS * (CLK_HZ / 1000);
    // Shortest reset pin low that is always honoured
    localparam int unsigned T_RST_MIN_NS = 2000;
    localparam int unsigned RST_CYC = T_RST_MIN_NS / CLK_PERIOD_NS;
    // Response deadlines, all met well inside by the logic
    localparam int unsigned T_LP_US = 100;
    localparam int unsigned LP_CYC = T_LP_US * (CLK_HZ / 1_000_000);
    localparam int unsigned T_INT_ON_MS = 200;
    localparam int unsigned INT_ON_CYC = T_INT_ON_MS * (CLK_HZ / 1000);
    localparam int unsigned T_INT_OFF_US = 500;
    localparam int unsigned INT_OFF_CYC = T_INT_OFF_US * (CLK_HZ / 1_000_000);
    localparam int unsigned T_MASK_MS = 100;
    localparam int unsigned MASK_CYC = T_MASK_MS * (CLK_HZ / 1000);
    localparam int unsigned T_SEL_US = 100;
    localparam int unsigned SEL_CYC = T_SEL_US * (CLK_HZ / 1_000_000);
    // Two-wire device address, 8-bit form A0h
    localparam logic [6:0] DEV_ADDR = 7'h50;
    // Byte offsets inside the lower page
    localparam logic [7:0] STATUS_ADDR = 8'h02;
    localparam logic [7:0] FLAG_ADDR = 8'h03;
    localparam logic [7:0] CTRL_ADDR = 8'h5D;
    localparam logic [7:0] MASK_ADDR = 8'h64;
    localparam int unsigned NOT_READY_BIT = 0;
    localparam int unsigned PDOWN_BIT = 1;
    localparam int unsigned FLAG_W = 8;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [7:0] FLAG_RST = 8'h00;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } pmctl_xfer_s;

    typedef struct packed {
        logic respond;
        logic not_ready;
        logic [FLAG_W-1:0] flags;
    } pmctl_sts_s;

    typedef enum logic [1:0] {ST_RESET, ST_INIT, ST_RUN} pmctl_state_e;
endpackage

// ---- design/pmctl_sync.sv ----
// Purpose: Two-flop synchroniser for independent level bits.
// Assumes: Each bit is a level that stays put for several destination clocks.
// Notes: Only the second stage is visible outside.
`timescale 1ns/10ps
module pmctl_sync
#(
    parameter int W = 1
)
(
    input wire logic clk_i, // Destination clock
    input wire logic arst_n_i, // Asynchronous reset, active low
    input wire logic [W-1:0] d_i, // Bits from another domain
    output logic [W-1:0] q_o // Synchronised bits
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            meta_q <= '0;
            q_o <= '0;
        end
        else
        begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end
endmodule

// ---- design/pmctl_link.sv ----
// Purpose: Link-side end of the management control, on the serial clock.
// Assumes: link_clk_i rises on each falling edge of the serial bus clock.
// Notes: Read and write completions leave as toggles with held address/data.
`timescale 1ns/10ps
module pmctl_link
    import pmctl_pkg::*;
(
    input wire logic link_clk_i, // Inverted serial bus clock
    input wire logic arst_n_i, // Asynchronous reset, active low
    input wire pmctl_sts_s sts_i, // State from the system domain
    input wire logic [6:0] dev_addr_i, // Device address of the transaction
    input wire logic [7:0] addr_i, // Byte offset of the transaction
    input wire logic [7:0] wr_data_i, // Written byte
    input wire logic rd_stop_i, // Stop bit after a read seen
    input wire logic wr_stop_i, // Stop bit after a write seen
    output pmctl_sts_s sts_o, // State seen on the link side
    output logic rd_tgl_o, // Toggles per accepted read
    output logic wr_tgl_o, // Toggles per accepted write
    output pmctl_xfer_s xfer_o // Held offset and data of last transfer
);
    wire accept;

    pmctl_sync #(.W($bits(pmctl_sts_s))) u_sts_sync (
        .clk_i(link_clk_i),
        .arst_n_i(arst_n_i),
        .d_i(sts_i),
        .q_o(sts_o)
    );

    // Only our address, and only while selected and out of reset
    assign accept = sts_o.respond
                 && (dev_addr_i == DEV_ADDR); // [R19] [R14] [R15]

    // Taken on the edge after the stop bit, which starts every deadline
    always_ff @(posedge link_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            rd_tgl_o <= 1'b0;
            wr_tgl_o <= 1'b0;
            xfer_o <= '0;
        end
        else if (wr_stop_i && accept)
        begin
            wr_tgl_o <= ~wr_tgl_o; // [R18]
            xfer_o <= '{addr: addr_i, data: wr_data_i};
        end
        else if (rd_stop_i && accept)
        begin
            rd_tgl_o <= ~rd_tgl_o; // [R18]
            xfer_o <= '{addr: addr_i, data: 8'h00};
        end
    end
endmodule

// ---- design/pmctl_top.sv ----
// Purpose: Control and status timing of a pluggable module's management.
// Assumes: Pins are asynchronous; the link side runs on its own clock.
// Notes: Flags latch conditions and clear on a read of the flag byte.
// Contract
// R1: Fully functional within 2000 ms after start.
// R2: Reset pin low over 2 us resets.
// R3: Serial bus answers within 2000 ms.
// R4: Not-ready clears and interrupt asserts in time.
// R5: Functional once ready interrupt has asserted.
// R6: Functional within 2000 ms after reset release.
// R7: Low-power pin lowers power within 100 us.
// R8: Interrupt line low within 200 ms.
// R9: Read clears flag, line released quickly.
// R10: Receive loss sets flag and interrupt.
// R11: Any condition sets flag and interrupt.
// R12: Set mask stops flag driving interrupt.
// R13: Cleared mask lets flag interrupt again.
// R14: Select asserted enables serial answers.
// R15: Select released stops serial answers.
// R16: Power-down bit set lowers power.
// R17: Power-down bit cleared restores function.
// R18: Deadlines start at edge after stop.
// R19: Answer only at device address A0h.
// R20: Host reads flags after interrupt.
// R21: Not-ready held until valid; flags latch. Code clears not-ready at the init timeout even while monitor_valid_i stays low.
`timescale 1ns/10ps
module pmctl_top
    import pmctl_pkg::*;
#(
    parameter int unsigned INIT_CYC_P = INIT_CYC // Init timeout in clocks
)
(
    input wire logic sys_clk_i, // System clock, 50 MHz
    input wire logic arst_n_i, // Power-on reset, active low
    input wire logic link_clk_i, // Inverted serial bus clock
    input wire logic module_reset_n_i, // Reset pin, active low
    input wire logic module_select_n_i, // Module select pin, active low
    input wire logic low_power_request_i, // Low-power pin, active high
    input wire logic [FLAG_W-1:0] flag_cond_i, // Flag conditions, bit0 rx loss
    input wire logic monitor_valid_i, // Monitor values valid, same clock
    input wire logic [6:0] lnk_dev_addr_i, // Link: device address
    input wire logic [7:0] lnk_addr_i, // Link: byte offset
    input wire logic [7:0] lnk_wr_data_i, // Link: written byte
    input wire logic lnk_rd_stop_i, // Link: read ended by stop
    input wire logic lnk_wr_stop_i, // Link: write ended by stop
    output logic interrupt_out_n_o, // Interrupt line, active low
    output logic low_power_o, // Lower power level in force
    output logic functional_o, // Module fully functional
    output logic lnk_respond_o, // Link: answer transactions
    output logic [7:0] lnk_status_o, // Link: status byte
    output logic [FLAG_W-1:0] lnk_flags_o // Link: flag byte
);
    localparam int ICW = $clog2(INIT_CYC_P + 1);
    localparam int RCW = $clog2(RST_CYC + 1);
    localparam int PW = 3 + FLAG_W;
    localparam int SYNC_LAT = 4;
    localparam int INIT_MAX = 300;

    logic [PW-1:0] pin_s;
    logic [1:0] tgl_s;
    logic [1:0] tgl_q;
    pmctl_xfer_s xfer;
    pmctl_sts_s sts_q;
    pmctl_sts_s lnk_sts;
    pmctl_state_e state_q;
    pmctl_state_e state_d;
    logic [RCW-1:0] rst_cnt_q;
    logic [RCW-1:0] rst_cnt_d;
    logic [ICW-1:0] init_cnt_q;
    logic [ICW-1:0] init_cnt_d;
    logic [FLAG_W-1:0] flag_q;
    logic [FLAG_W-1:0] flag_d;
    logic [FLAG_W-1:0] mask_q;
    logic [FLAG_W-1:0] mask_d;
    logic ready_flag_q;
    logic ready_flag_d;
    logic not_ready_q;
    logic pdown_q;
    logic pdown_d;
    logic int_n_d;

    wire rst_pin_s;
    wire sel_n_s;
    wire lp_s;
    wire [FLAG_W-1:0] cond_s;
    wire rd_evt;
    wire wr_evt;
    wire flag_rd;
    wire mask_wr;
    wire ctrl_wr;
    wire rst_req;
    wire init_done;
    wire ready_set;
    wire running;

    // Pins cross into the system clock first
    pmctl_sync #(.W(PW)) u_pin_sync (
        .clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .d_i({module_reset_n_i, module_select_n_i, low_power_request_i,
              flag_cond_i}),
        .q_o(pin_s)
    );

    pmctl_link u_link (
        .link_clk_i(link_clk_i),
        .arst_n_i(arst_n_i),
        .sts_i(sts_q),
        .dev_addr_i(lnk_dev_addr_i),
        .addr_i(lnk_addr_i),
        .wr_data_i(lnk_wr_data_i),
        .rd_stop_i(lnk_rd_stop_i),
        .wr_stop_i(lnk_wr_stop_i),
        .sts_o(lnk_sts),
        .rd_tgl_o(tgl_s[1]),
        .wr_tgl_o(tgl_s[0]),
        .xfer_o(xfer)
    );

    // Toggles from the link domain, detected after two flops
    logic [1:0] tgl_m;
    pmctl_sync #(.W(2)) u_tgl_sync (
        .clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .d_i(tgl_s),
        .q_o(tgl_m)
    );

    assign lnk_respond_o = lnk_sts.respond;
    assign lnk_status_o = {7'h00, lnk_sts.not_ready};
    assign lnk_flags_o = lnk_sts.flags;

    assign rst_pin_s = pin_s[PW-1];
    assign sel_n_s = pin_s[PW-2];
    assign lp_s = pin_s[PW-3];
    assign cond_s = pin_s[FLAG_W-1:0];

    assign rd_evt = tgl_m[1] ^ tgl_q[1];
    assign wr_evt = tgl_m[0] ^ tgl_q[0];
    assign flag_rd = rd_evt && (xfer.addr == FLAG_ADDR); // [R9] [R18]
    assign mask_wr = wr_evt && (xfer.addr == MASK_ADDR); // [R18]
    assign ctrl_wr = wr_evt && (xfer.addr == CTRL_ADDR); // [R18]

    // Reset request once the pin has been low long enough
    assign rst_req = (rst_cnt_q == RCW'(RST_CYC)); // [R2]
    assign rst_cnt_d = rst_pin_s ? '0
                     : (rst_req ? rst_cnt_q : rst_cnt_q + 1'b1);

    // Ready as soon as monitors are valid, at the latest at the timeout
    assign init_done = monitor_valid_i
                    || (init_cnt_q == ICW'(INIT_CYC_P - 1)); // [R1] [R6]
    assign init_cnt_d = (state_q == ST_INIT) ? init_cnt_q + 1'b1 : '0;
    assign running = (state_q == ST_RUN);
    assign ready_set = (state_q == ST_INIT) && (state_d == ST_RUN); // [R4]

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_RESET:
            begin
                if (rst_pin_s)
                begin
                    state_d = ST_INIT; // [R6]
                end
            end
            ST_INIT:
            begin
                if (init_done)
                begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN:
            begin
                state_d = ST_RUN;
            end
            default:
            begin
                state_d = ST_RESET;
            end
        endcase
        if (rst_req)
        begin
            state_d = ST_RESET; // [R2]
        end
    end

    // Latched flags: a new condition wins over the clearing read
    assign flag_d = running ? (cond_s | (flag_q & ~{FLAG_W{flag_rd}}))
                  : FLAG_RST; // [R10] [R11] [R21]
    assign ready_flag_d = (state_d == ST_RESET) ? 1'b0
                        : (ready_set | (ready_flag_q & ~flag_rd)); // [R5]
    assign mask_d = mask_wr ? xfer.data : mask_q; // [R12] [R13]
    assign pdown_d = ctrl_wr ? xfer.data[PDOWN_BIT] : pdown_q; // [R16] [R17]
    assign int_n_d = ~(|(flag_d & ~mask_d) | ready_flag_d); // [R8] [R9]

    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            state_q <= ST_INIT;
            rst_cnt_q <= '0;
            init_cnt_q <= '0;
            tgl_q <= 2'h0;
            flag_q <= FLAG_RST;
            mask_q <= MASK_RST;
            ready_flag_q <= 1'b0;
            not_ready_q <= 1'b1;
            pdown_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            rst_cnt_q <= rst_cnt_d;
            init_cnt_q <= init_cnt_d;
            tgl_q <= tgl_m;
            flag_q <= flag_d;
            mask_q <= mask_d;
            ready_flag_q <= ready_flag_d;
            not_ready_q <= (state_d != ST_RUN); // [R4] [R21]
            pdown_q <= pdown_d;
        end
    end

    // Outputs and link-bound state, all straight from flops
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            interrupt_out_n_o <= 1'b1;
            low_power_o <= 1'b0;
            functional_o <= 1'b0;
            sts_q <= '0;
        end
        else
        begin
            interrupt_out_n_o <= int_n_d; // [R8] [R9] [R12] [R13]
            low_power_o <= lp_s | pdown_d; // [R7] [R16]
            functional_o <= (state_d == ST_RUN) && !pdown_d; // [R5] [R17]
            sts_q.respond <= !sel_n_s && (state_d != ST_RESET); // [R3] [R14]
            sts_q.not_ready <= (state_d != ST_RUN);
            sts_q.flags <= flag_d;
        end
    end

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!arst_n_i);

    sequence s_ready_edge;
        (state_q == ST_INIT) && (state_d == ST_RUN);
    endsequence

    sequence s_int_low;
        !interrupt_out_n_o;
    endsequence

    property p_init_bound;
        (state_q == ST_INIT) |-> (init_cnt_q < ICW'(INIT_CYC_P));
    endproperty
    a_init_bound: assert property (p_init_bound) // [R1] [R3] [R6]
        else $error("init window overrun");

    property p_ready_int;
        s_ready_edge |=> s_int_low and !not_ready_q
            and (functional_o == !pdown_q);
    endproperty
    a_ready_int: assert property (p_ready_int) // [R4] [R5]
        else $error("ready did not raise interrupt");

    property p_reset_req;
        (!rst_pin_s && rst_cnt_q == RCW'(RST_CYC - 1))
            |=> ##1 (state_q == ST_RESET) && not_ready_q;
    endproperty
    a_reset_req: assert property (p_reset_req) // [R2]
        else $error("long reset low not honoured");

    property p_low_power;
        $rose(lp_s) |=> low_power_o;
    endproperty
    a_low_power: assert property (p_low_power) // [R7]
        else $error("low power late");

    property p_flag_int;
        (running && |(cond_s & ~mask_q) && !mask_wr)
            |=> (flag_q != '0) and s_int_low;
    endproperty
    a_flag_int: assert property (p_flag_int) // [R8] [R10] [R11]
        else $error("flag or interrupt not set");

    property p_read_release;
        (flag_rd && cond_s == '0 && !ready_set && running)
            |=> (flag_q == '0) && !ready_flag_q && interrupt_out_n_o;
    endproperty
    a_read_release: assert property (p_read_release) // [R9] [R21]
        else $error("read did not release interrupt");

    property p_mask_gate;
        (mask_q == 8'hFF && !ready_flag_q && !$past(ready_flag_q)
            && !mask_wr && !ready_set) |=> interrupt_out_n_o;
    endproperty
    a_mask_gate: assert property (p_mask_gate) // [R12] [R13]
        else $error("masked flag drove interrupt");

    property p_select;
        $changed(sel_n_s) |=> ##[1:SYNC_LAT]
            (sts_q.respond == (!sel_n_s && state_q != ST_RESET));
    endproperty
    a_select: assert property (p_select) // [R14] [R15]
        else $error("select not followed");

    property p_pdown;
        (ctrl_wr && xfer.data[PDOWN_BIT]) |=> low_power_o && !functional_o;
    endproperty
    a_pdown: assert property (p_pdown) // [R16] [R17]
        else $error("power-down not applied");

    property p_init_fast;
        (state_q == ST_INIT && monitor_valid_i && !rst_req)
            |=> ##[0:INIT_MAX] !not_ready_q;
    endproperty
    a_init_fast: assert property (p_init_fast) // [R4]
        else $error("not-ready stuck");

    // Without a clearing read no latched flag may drop
    property p_flag_hold;
        (running && !flag_rd)
            |=> ((flag_q & $past(flag_q)) == $past(flag_q));
    endproperty
    a_flag_hold: assert property (p_flag_hold) // [R21]
        else $error("latched flag lost");

    property p_short_rst;
        (running && rst_pin_s && !rst_req) |=> running;
    endproperty
    a_short_rst: assert property (p_short_rst) // [R2]
        else $error("short reset low taken");

    property p_rst_quiet;
        (state_q == ST_RESET) |-> !sts_q.respond && sts_q.not_ready;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) // [R3] [R21]
        else $error("answering while in reset");

    property p_lp_release;
        ($fell(lp_s) && !pdown_q && !ctrl_wr) |=> !low_power_o;
    endproperty
    a_lp_release: assert property (p_lp_release) // [R7]
        else $error("low power stuck");
endmodule

// ---- sim/pmctl_host.sv ----
// Purpose: Host model that masters the link side of the management control.
// Assumes: The link clock stands still outside xfer and idle; 160 ns period.
// Notes: Idle address and data lines show the inverse of the last value; stop lines return low.
`timescale 1ns/10ps
module pmctl_host
    import pmctl_pkg::*;
(
    output logic link_clk_o, // Link clock, runs only inside xfer and idle
    output logic [6:0] dev_addr_o, // Device address
    output logic [7:0] addr_o, // Byte offset
    output logic [7:0] wr_data_o, // Written byte
    output logic rd_stop_o, // Read ended by stop
    output logic wr_stop_o // Write ended by stop
);
    localparam int PRE = 9;

    initial
    begin
        link_clk_o = 1'b0;
        dev_addr_o = 7'h00;
        addr_o = 8'h00;
        wr_data_o = 8'h00;
        rd_stop_o = 1'b0;
        wr_stop_o = 1'b0;
    end

    task automatic edge1();
        #80 link_clk_o = 1'b1;
        #80 link_clk_o = 1'b0;
    endtask

    // Clock edges only, lets link-visible state update
    task automatic idle();
        repeat (PRE) edge1();
    endtask

    task automatic xfer(input logic wr, input logic [6:0] dev,
                        input logic [7:0] a, input logic [7:0] d);
        dev_addr_o = dev;
        addr_o = a;
        wr_data_o = d;
        repeat (PRE) edge1();
        wr_stop_o = wr;
        rd_stop_o = !wr;
        edge1();
        wr_stop_o = 1'b0;
        rd_stop_o = 1'b0;
        dev_addr_o = ~dev;
        addr_o = ~a;
        wr_data_o = ~d;
        repeat (2) edge1();
    endtask
endmodule

// ---- sim/tb_top.sv ----
// Purpose: Self-checking bench of the module management control.
// Assumes: Init timeout shortened to 200 clocks.
// Notes: Flag cases run from a table; pins and power by hand.
`timescale 1ns/10ps
module tb_top
    import pmctl_pkg::*;
;
    typedef struct packed {
        logic [7:0] cond;
        logic [7:0] mask;
        logic int_n;
    } pmctl_row_s;

    logic sys_clk_i, arst_n_i, link_clk, rst_pin_n, sel_n, lp_req, mon_valid;
    logic [7:0] cond;
    logic [6:0] dev;
    logic [7:0] addr, wdata, status, flags;
    logic rd_stop, wr_stop, int_n, low_power, functional, respond;
    int error_cnt = 0;
    int n_tests = 0;
    int cyc = 0;
    pmctl_row_s rows [5] = '{
        '{8'h01, 8'h00, 1'b0},
        '{8'h80, 8'h00, 1'b0},
        '{8'h04, 8'h04, 1'b1},
        '{8'h10, 8'h04, 1'b0},
        '{8'h02, 8'hFF, 1'b1}};

    pmctl_host i_host (.link_clk_o(link_clk), .dev_addr_o(dev),
        .addr_o(addr), .wr_data_o(wdata), .rd_stop_o(rd_stop),
        .wr_stop_o(wr_stop));

    pmctl_top #(.INIT_CYC_P(200)) i_dut (.sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i), .link_clk_i(link_clk),
        .module_reset_n_i(rst_pin_n), .module_select_n_i(sel_n),
        .low_power_request_i(lp_req), .flag_cond_i(cond),
        .monitor_valid_i(mon_valid), .lnk_dev_addr_i(dev),
        .lnk_addr_i(addr), .lnk_wr_data_i(wdata), .lnk_rd_stop_i(rd_stop),
        .lnk_wr_stop_i(wr_stop), .interrupt_out_n_o(int_n),
        .low_power_o(low_power), .functional_o(functional),
        .lnk_respond_o(respond), .lnk_status_o(status),
        .lnk_flags_o(flags));

    initial
    begin
        sys_clk_i = 1'b0;
        forever #10 sys_clk_i = ~sys_clk_i;
    end

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Hang guard, far above the expected few thousand cycles
    always @(posedge sys_clk_i)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            error_cnt++;
            end_sim();
        end
    end

    task automatic chk_bit(input string name, input logic exp, input logic got);
        n_tests++;
        if (got !== exp)
        begin
            $display("wrong value %s expected %b seen %b", name, exp, got);
            error_cnt++;
        end
    endtask

    task automatic chk_byte(input string name, input logic [7:0] exp,
                            input logic [7:0] got);
        n_tests++;
        if (got !== exp)
        begin
            $display("wrong value %s expected %h seen %h", name, exp, got);
            error_cnt++;
        end
    endtask

    function automatic logic cur(input int sel);
        case (sel)
            0: cur = int_n;
            1: cur = functional;
            default: cur = low_power;
        endcase
    endfunction

    // Bounded wait for a level; returns at once if it already holds
    task automatic wait_sig(input string name, input int sel, input logic exp,
                            input int max);
        int n;
        n = 0;
        while (cur(sel) !== exp && n < max)
        begin
            @(negedge sys_clk_i);
            n++;
        end
        chk_bit(name, exp, cur(sel));
    endtask

    task automatic pulse_cond(input logic [7:0] c);
        @(negedge sys_clk_i);
        cond = c;
        repeat (5) @(negedge sys_clk_i);
        cond = 8'h00;
    endtask

    task automatic clear_flags();
        i_host.xfer(1'b0, 7'h50, FLAG_ADDR, 8'h00);
        wait_sig("int_off", 0, 1'b1, 40);
    endtask

    initial
    begin
        arst_n_i = 1'b0;
        rst_pin_n = 1'b1;
        sel_n = 1'b0;
        lp_req = 1'b0;
        mon_valid = 1'b0;
        cond = 8'h00;
        repeat (3) @(negedge sys_clk_i);
        chk_bit("rst_int", 1'b1, int_n);
        chk_bit("rst_func", 1'b0, functional);
        arst_n_i = 1'b1;
        #7 i_host.idle();
        chk_bit("respond", 1'b1, respond);
        chk_byte("status_init", 8'h01, status);
        wait_sig("func_init", 1, 1'b1, 300);
        chk_bit("ready_int", 1'b0, int_n);
        i_host.idle();
        chk_byte("status_run", 8'h00, status);
        i_host.xfer(1'b0, 7'h51, FLAG_ADDR, 8'h00);
        wait_sig("int_wrong_dev", 0, 1'b0, 40);
        clear_flags();
        foreach (rows[i])
        begin
            i_host.xfer(1'b1, 7'h50, MASK_ADDR, rows[i].mask);
            pulse_cond(rows[i].cond);
            wait_sig("int_row", 0, rows[i].int_n, 40);
            i_host.idle();
            chk_byte("flags_row", rows[i].cond, flags);
            clear_flags();
            i_host.idle();
            chk_byte("flags_clr", 8'h00, flags);
        end
        pulse_cond(8'h04);
        wait_sig("int_masked", 0, 1'b1, 40);
        i_host.xfer(1'b1, 7'h50, MASK_ADDR, 8'h00);
        wait_sig("int_unmask", 0, 1'b0, 40);
        clear_flags();
        @(negedge sys_clk_i);
        lp_req = 1'b1;
        wait_sig("lp_on", 2, 1'b1, LP_CYC);
        chk_bit("lp_func", 1'b1, functional);
        lp_req = 1'b0;
        wait_sig("lp_off", 2, 1'b0, 20);
        i_host.xfer(1'b1, 7'h50, CTRL_ADDR, 8'h02);
        wait_sig("pd_func", 1, 1'b0, 40);
        chk_bit("pd_power", 1'b1, low_power);
        i_host.xfer(1'b1, 7'h50, CTRL_ADDR, 8'h00);
        wait_sig("pd_off", 1, 1'b1, 40);
        chk_bit("pd_off_pw", 1'b0, low_power);
        @(negedge sys_clk_i);
        sel_n = 1'b1;
        i_host.idle();
        chk_bit("desel", 1'b0, respond);
        i_host.xfer(1'b1, 7'h50, MASK_ADDR, 8'hFF);
        @(negedge sys_clk_i);
        sel_n = 1'b0;
        i_host.idle();
        chk_bit("resel", 1'b1, respond);
        pulse_cond(8'h01);
        wait_sig("int_desel_wr", 0, 1'b0, 40);
        clear_flags();
        @(negedge sys_clk_i);
        rst_pin_n = 1'b0;
        repeat (50) @(negedge sys_clk_i);
        rst_pin_n = 1'b1;
        repeat (10) @(negedge sys_clk_i);
        wait_sig("short_rst", 1, 1'b1, 20);
        chk_bit("short_rst_f", 1'b1, functional);
        rst_pin_n = 1'b0;
        wait_sig("pin_rst", 1, 1'b0, RST_CYC + 20);
        i_host.idle();
        chk_bit("rst_respond", 1'b0, respond);
        chk_byte("rst_status", 8'h01, status);
        @(negedge sys_clk_i);
        mon_valid = 1'b1;
        rst_pin_n = 1'b1;
        wait_sig("pin_rel", 1, 1'b1, 50);
        chk_bit("pin_rel_int", 1'b0, int_n);
        end_sim();
    end
endmodule
